// ===== common/frame_codec_pkg.sv
// shared constants, types and check function for the frame codec ends
`default_nettype none
package frame_codec_pkg;
  // ------------------------------------------------------------------
  // field widths and limits
  // ------------------------------------------------------------------
  localparam int          ID_W          = 10;
  localparam int          COUNT_W       = 4;
  localparam int          ROUND_W       = 8;
  localparam int          CRC_W         = 16;
  localparam int          BYTE_W        = 8;
  localparam int          MAX_PAYLOAD   = 12;
  localparam int          MAX_PAYLOAD_V2 = 11;
  localparam int          POS_W         = 5;
  localparam logic [3:0]  MAX_COUNT     = 4'hC;
  localparam logic [3:0]  MAX_COUNT_V2  = 4'hB;
  localparam logic [9:0]  ID_NONE       = 10'h000;
  // ------------------------------------------------------------------
  // wire layout: header byte 0 = id[9:2], byte 1 = {id[1:0],flag,sync,count}
  // ------------------------------------------------------------------
  localparam int          HDR1_ID_LSB   = 6;
  localparam int          HDR1_FLAG_BIT = 5;
  localparam int          HDR1_SYNC_BIT = 4;
  localparam logic [4:0]  POS_HDR0      = 5'h00;
  localparam logic [4:0]  POS_HDR1      = 5'h01;
  localparam logic [4:0]  POS_CYC       = 5'h02;
  localparam logic [4:0]  HDR_BYTES     = 5'h02;
  // ------------------------------------------------------------------
  // check field
  // ------------------------------------------------------------------
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [7:0]  CNT_MAX       = 8'hFF;
  localparam int          FIFO_DEPTH    = 4;

  typedef enum logic [1:0] {RC_STATIC, RC_MIXED, RC_DYNAMIC} round_cfg_e;

  // msb-first crc over one byte; the polynomial is CRC_POLY from this package
  function automatic logic [15:0] crc_next(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ b[i]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : crc_next
endpackage : frame_codec_pkg
`default_nettype wire

// ===== common/frame_link_if.sv
// byte-stream link joining the frame sender end and the frame receiver end
`timescale 1ns/10ps
`default_nettype none
interface frame_link_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       last;

  modport tx (output valid, output data, output last, input ready);
  modport rx (input valid, input data, input last, output ready);
endinterface : frame_link_if
`default_nettype wire

// ===== verilog/frame_rx_end.sv
// frame receiver end: input buffer, parser, sync acceptance, round counter
//
// Function
// - identifier is 10 bits, zero never valid
// - identifier means slot static, priority dynamic
// - one multiplex flag bit per frame
// - sync tag marks clock-sync input frames
// - 4-bit count, 0..12 bytes, exact payload
// - 16-bit check field sent and verified
// - variant two carries 8-bit round field
// - round field is counter or data byte
// - round counter increments at each round start
// - variant two sync tag means counter present
// - variant two payload limited to 0..11
// - only static sync frames feed clock sync
// - no clock sync in pure dynamic config
`timescale 1ns/10ps
`default_nettype none
module frame_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("frame_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      fill_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (fill_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (fill_ff != '0);
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      fill_ff   <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      fill_ff <= fill_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : frame_fifo

module frame_rx_end
  import frame_codec_pkg::*;
#(
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_b_i,
  // link from the sending node
  frame_link_if.rx                      link,
  // configuration and schedule
  input  wire logic                     variant2_i,
  input  wire round_cfg_e               round_cfg_i,
  input  wire logic                     dynamic_seg_i,
  input  wire logic                     cycle_start_i,
  // parsed frame
  output logic                          rx_valid_o,
  input  wire logic                     rx_ready_i,
  output logic [ID_W-1:0]               slot_o,
  output logic [ID_W-1:0]               priority_o,
  output logic                          same_slot_variant_flag_o,
  output logic                          sync_o,
  output logic [COUNT_W-1:0]            payload_byte_count_o,
  output logic [ROUND_W-1:0]            cycle_field_o,
  output logic [MAX_PAYLOAD*BYTE_W-1:0] payload_o,
  // status
  output logic                          sync_accept_o,
  output logic                          round_mismatch_o,
  output logic [ROUND_W-1:0]            round_count_o,
  output logic [7:0]                    format_err_cnt_o,
  output logic [7:0]                    crc_err_cnt_o
);
  typedef enum {RX_HDR0, RX_HDR1, RX_CYC, RX_DATA, RX_CRCH, RX_CRCL, RX_DROP, RX_HOLD} rx_state_e;

  // ------------------------------------------------------------------
  // input buffer
  // ------------------------------------------------------------------
  logic       buf_valid;
  logic       buf_pop_ready;
  logic [8:0] buf_data;
  logic [7:0] b;
  logic       b_last;
  logic       pop;

  frame_fifo #(.WIDTH(9), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (link.valid),
    .in_ready_o  (link.ready),
    .in_data_i   ({link.last, link.data}),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop_ready),
    .out_data_o  (buf_data)
  );

  rx_state_e            state_ff;
  logic [ID_W-1:0]      id_ff;
  logic [7:0]           id_hi_ff;
  logic                 flag_ff;
  logic                 sync_ff;
  logic [COUNT_W-1:0]   count_ff;
  logic [COUNT_W-1:0]   idx_ff;
  logic [ROUND_W-1:0]   cyc_ff;
  logic [7:0]           crc_hi_ff;
  logic [CRC_W-1:0]     crc_ff;
  logic [7:0]           pay_ff [MAX_PAYLOAD];
  logic                 dyn_ff;
  logic                 v2_ff;
  logic [ROUND_W-1:0]   round_ff;
  logic [ID_W-1:0]      hdr_id;
  logic [COUNT_W-1:0]   hdr_count;
  logic                 hdr_bad;
  logic                 done_ok;
  logic                 fmt_err;
  logic                 crc_err;

  // stalls while a parsed frame waits, so the buffer really fills
  assign buf_pop_ready = (state_ff != RX_HOLD);
  assign pop           = buf_valid & buf_pop_ready;
  assign b             = buf_data[7:0];
  assign b_last        = buf_data[8];

  // ------------------------------------------------------------------
  // header decode
  // ------------------------------------------------------------------
  assign hdr_id    = {id_hi_ff, b[7:HDR1_ID_LSB]};
  assign hdr_count = b[COUNT_W-1:0];
  assign hdr_bad   = (hdr_id == ID_NONE)
                   | (hdr_count > (variant2_i ? MAX_COUNT_V2 : MAX_COUNT));

  assign done_ok = pop & (state_ff == RX_CRCL) & b_last & ({crc_hi_ff, b} == crc_ff);
  assign crc_err = pop & (state_ff == RX_CRCL) & b_last & ({crc_hi_ff, b} != crc_ff);

  always_comb begin
    fmt_err = 1'b0;
    if (pop) begin
      case (state_ff)
        RX_HDR0:                    fmt_err = b_last;
        RX_HDR1:                    fmt_err = hdr_bad | b_last;
        RX_CYC, RX_DATA, RX_CRCH:   fmt_err = b_last;
        RX_CRCL:                    fmt_err = ~b_last;
        default:                    fmt_err = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // parser state
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= RX_HDR0;
    end else if (state_ff == RX_HOLD) begin
      if (rx_ready_i) begin
        state_ff <= RX_HDR0;
      end
    end else if (pop) begin
      case (state_ff)
        RX_HDR0: state_ff <= b_last ? RX_HDR0 : RX_HDR1;
        RX_HDR1: begin
          if (b_last) begin
            state_ff <= RX_HDR0;
          end else if (hdr_bad) begin
            state_ff <= RX_DROP;
          end else if (variant2_i) begin
            state_ff <= RX_CYC;
          end else begin
            state_ff <= (hdr_count == '0) ? RX_CRCH : RX_DATA;
          end
        end
        RX_CYC:  state_ff <= b_last ? RX_HDR0 : ((count_ff == '0) ? RX_CRCH : RX_DATA);
        RX_DATA: begin
          if (b_last) begin
            state_ff <= RX_HDR0;
          end else if (idx_ff == count_ff - 1'b1) begin
            state_ff <= RX_CRCH;
          end
        end
        RX_CRCH: state_ff <= b_last ? RX_HDR0 : RX_CRCL;
        RX_CRCL: state_ff <= !b_last ? RX_DROP : (done_ok ? RX_HOLD : RX_HDR0);
        RX_DROP: state_ff <= b_last ? RX_HDR0 : RX_DROP;
        default: state_ff <= RX_HDR0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // field capture and running check
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      id_hi_ff  <= '0;
      id_ff     <= '0;
      flag_ff   <= 1'b0;
      sync_ff   <= 1'b0;
      count_ff  <= '0;
      idx_ff    <= '0;
      cyc_ff    <= '0;
      crc_hi_ff <= '0;
      crc_ff    <= CRC_INIT;
      v2_ff     <= 1'b0;
    end else if (pop) begin
      case (state_ff)
        RX_HDR0: begin
          id_hi_ff <= b;
          crc_ff   <= crc_next(CRC_INIT, b);
        end
        RX_HDR1: begin
          id_ff    <= hdr_id;
          flag_ff  <= b[HDR1_FLAG_BIT];
          sync_ff  <= b[HDR1_SYNC_BIT];
          count_ff <= hdr_count;
          v2_ff    <= variant2_i;
          idx_ff   <= '0;
          crc_ff   <= crc_next(crc_ff, b);
        end
        RX_CYC: begin
          cyc_ff <= b;
          crc_ff <= crc_next(crc_ff, b);
        end
        RX_DATA: begin
          idx_ff <= idx_ff + 1'b1;
          crc_ff <= crc_next(crc_ff, b);
        end
        RX_CRCH: crc_hi_ff <= b;
        default: crc_hi_ff <= crc_hi_ff;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (pop && state_ff == RX_DATA) begin
      pay_ff[idx_ff] <= b;
    end
  end

  // ------------------------------------------------------------------
  // segment, sync acceptance, round counter
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dyn_ff           <= 1'b0;
      sync_accept_o    <= 1'b0;
      round_mismatch_o <= 1'b0;
    end else begin
      if (done_ok) begin
        dyn_ff <= dynamic_seg_i;
      end
      sync_accept_o    <= done_ok & sync_ff & ~dynamic_seg_i & (round_cfg_i != RC_DYNAMIC);
      // counter copy checked only when the tag says it is a counter
      round_mismatch_o <= done_ok & v2_ff & sync_ff & (cyc_ff != round_ff);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      round_ff <= '0;
    end else if (cycle_start_i) begin
      round_ff <= round_ff + 1'b1;
    end
  end

  // saturating so a noisy bus cannot wrap the figures back to small
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      format_err_cnt_o <= '0;
      crc_err_cnt_o    <= '0;
    end else begin
      if (fmt_err && format_err_cnt_o != CNT_MAX) begin
        format_err_cnt_o <= format_err_cnt_o + 1'b1;
      end
      if (crc_err && crc_err_cnt_o != CNT_MAX) begin
        crc_err_cnt_o <= crc_err_cnt_o + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign rx_valid_o               = (state_ff == RX_HOLD);
  assign slot_o                   = dyn_ff ? ID_NONE : id_ff;
  assign priority_o               = dyn_ff ? id_ff : ID_NONE;
  assign same_slot_variant_flag_o = flag_ff;
  assign sync_o                   = sync_ff;
  assign payload_byte_count_o     = count_ff;
  assign cycle_field_o            = cyc_ff;
  assign round_count_o            = round_ff;

  for (genvar g = 0; g < MAX_PAYLOAD; g++) begin : g_pay
    assign payload_o[g*BYTE_W +: BYTE_W] = pay_ff[g];
  end
endmodule : frame_rx_end
`default_nettype wire

// ===== verilog/frame_tx_end.sv
// frame sender end: checks a request, builds and streams the frame bytes
`timescale 1ns/10ps
`default_nettype none
module frame_tx_end
  import frame_codec_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_b_i,
  // link toward the receiving node
  frame_link_if.tx                      link,
  // schedule
  input  wire logic                     cycle_start_i,
  // frame request
  input  wire logic                     tx_valid_i,
  output logic                          tx_ready_o,
  input  wire logic                     variant2_i,
  input  wire logic [ID_W-1:0]          id_i,
  input  wire logic                     same_slot_variant_flag_i,
  input  wire logic                     sync_i,
  input  wire logic [COUNT_W-1:0]       payload_byte_count_i,
  input  wire logic [ROUND_W-1:0]       cycle_data_i,
  input  wire logic [MAX_PAYLOAD*BYTE_W-1:0] payload_i,
  // status
  output logic                          tx_refused_o,
  output logic [ROUND_W-1:0]            round_count_o
);
  typedef enum {TX_IDLE, TX_SEND} tx_state_e;

  tx_state_e                   state_ff;
  logic [POS_W-1:0]            pos_ff;
  logic [POS_W-1:0]            nxt_pos;
  logic [POS_W-1:0]            crc_pos_ff;
  logic [POS_W-1:0]            data_pos_ff;
  logic [POS_W-1:0]            idx;
  logic [15:0]                 hdr_ff;
  logic                        v2_ff;
  logic [ROUND_W-1:0]          cyc_ff;
  logic [MAX_PAYLOAD*BYTE_W-1:0] pay_ff;
  logic [CRC_W-1:0]            crc_ff;
  logic [CRC_W-1:0]            nxt_crc;
  logic [7:0]                  data_ff;
  logic [7:0]                  nxt_data;
  logic                        valid_ff;
  logic                        last_ff;
  logic                        accept;
  logic                        req_bad;
  logic                        beat;
  logic [ROUND_W-1:0]          round_ff;
  logic [POS_W-1:0]            req_data_pos;

  assign tx_ready_o   = (state_ff == TX_IDLE);
  assign req_bad      = (id_i == ID_NONE)
                      | (payload_byte_count_i > (variant2_i ? MAX_COUNT_V2 : MAX_COUNT));
  assign accept       = tx_valid_i & tx_ready_o & ~req_bad;
  assign beat         = valid_ff & link.ready;
  assign req_data_pos = HDR_BYTES + POS_W'(variant2_i);

  // ------------------------------------------------------------------
  // next byte selection
  // ------------------------------------------------------------------
  assign nxt_pos = pos_ff + 1'b1;
  assign nxt_crc = (pos_ff < crc_pos_ff) ? crc_next(crc_ff, data_ff) : crc_ff;
  assign idx     = nxt_pos - data_pos_ff;

  always_comb begin
    nxt_data = 8'h00;
    if (nxt_pos == POS_HDR1) begin
      nxt_data = hdr_ff[7:0];
    end else if (v2_ff && nxt_pos == POS_CYC) begin
      nxt_data = cyc_ff;
    end else if (nxt_pos < crc_pos_ff) begin
      nxt_data = pay_ff[idx[COUNT_W-1:0]*BYTE_W +: BYTE_W];
    end else if (nxt_pos == crc_pos_ff) begin
      nxt_data = nxt_crc[15:8];
    end else begin
      nxt_data = crc_ff[7:0];
    end
  end

  // ------------------------------------------------------------------
  // request capture and sequencing
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= TX_IDLE;
    end else if (accept) begin
      state_ff <= TX_SEND;
    end else if (beat && last_ff) begin
      state_ff <= TX_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hdr_ff      <= '0;
      v2_ff       <= 1'b0;
      cyc_ff      <= '0;
      pay_ff      <= '0;
      data_pos_ff <= '0;
      crc_pos_ff  <= '0;
    end else if (accept) begin
      hdr_ff      <= {id_i, same_slot_variant_flag_i, sync_i, payload_byte_count_i};
      v2_ff       <= variant2_i;
      // tagged frames carry the live round count, others a data byte
      cyc_ff      <= sync_i ? round_ff : cycle_data_i;
      pay_ff      <= payload_i;
      data_pos_ff <= req_data_pos;
      crc_pos_ff  <= req_data_pos + POS_W'(payload_byte_count_i);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_ff   <= '0;
      crc_ff   <= CRC_INIT;
      data_ff  <= '0;
      valid_ff <= 1'b0;
      last_ff  <= 1'b0;
    end else if (accept) begin
      pos_ff   <= POS_HDR0;
      crc_ff   <= CRC_INIT;
      data_ff  <= id_i[ID_W-1:ID_W-8];
      valid_ff <= 1'b1;
      last_ff  <= 1'b0;
    end else if (beat) begin
      pos_ff   <= nxt_pos;
      crc_ff   <= nxt_crc;
      data_ff  <= nxt_data;
      valid_ff <= ~last_ff;
      last_ff  <= (nxt_pos == crc_pos_ff + 1'b1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_refused_o <= 1'b0;
    end else begin
      tx_refused_o <= tx_valid_i & tx_ready_o & req_bad;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      round_ff <= '0;
    end else if (cycle_start_i) begin
      round_ff <= round_ff + 1'b1;
    end
  end

  assign link.valid    = valid_ff;
  assign link.data     = data_ff;
  assign link.last     = last_ff;
  assign round_count_o = round_ff;
endmodule : frame_tx_end
`default_nettype wire

// ===== dv/frame_link_properties.sv
// link handshake and frame format properties for the frame codec
`timescale 1ns/10ps
`default_nettype none
module frame_link_properties (
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  // link
  input wire logic       valid,
  input wire logic       ready,
  input wire logic [7:0] data,
  input wire logic       last
);
  logic [4:0] pos_ff;
  logic [7:0] hdr0_ff;
  logic [3:0] cnt_ff;
  logic       beat;
  assign beat = valid && ready;
  // byte position within the frame; variant is not on the wire, so both lengths pass
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_ff <= 5'h00;
      hdr0_ff <= 8'h00;
      cnt_ff <= 4'h0;
    end else if (beat) begin
      pos_ff <= last ? 5'h00 : pos_ff + 5'h01;
      hdr0_ff <= (pos_ff == 5'h00) ? data : hdr0_ff;
      cnt_ff <= (pos_ff == 5'h01) ? data[3:0] : cnt_ff;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  AST_VALID_HOLD: assert property (valid && !ready |=> valid)
    else $error("link valid dropped before taken");
  AST_DATA_HOLD: assert property (valid && !ready |=> $stable(data) && $stable(last))
    else $error("link byte changed before taken");
  AST_ID_NONZERO: assert property (beat && pos_ff == 5'h01 |-> {hdr0_ff, data[7:6]} != 10'h000)
    else $error("zero identifier sent");
  AST_COUNT_MAX: assert property (beat && pos_ff == 5'h01 |-> data[3:0] <= 4'hC)
    else $error("byte count above twelve");
  AST_FRAME_LEN: assert property (beat && last |->
    pos_ff == {1'b0, cnt_ff} + 5'h03 || pos_ff == {1'b0, cnt_ff} + 5'h04)
    else $error("frame length disagrees with count");
  AST_V2_COUNT: assert property (beat && last && pos_ff == {1'b0, cnt_ff} + 5'h04 |->
    cnt_ff <= 4'hB)
    else $error("variant two count above eleven");
  AST_MIN_LEN: assert property (valid && pos_ff < 5'h03 |-> !last)
    else $error("frame ended before check field");
  AST_IDLE_AFTER: assert property (beat && last |=> !valid)
    else $error("no idle cycle after frame");
  AST_BACK_TO_BACK: assert property (beat && !last |=> valid)
    else $error("gap inside frame");
endmodule : frame_link_properties
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench: sender and receiver ends joined over the link
`timescale 1ns/10ps
`default_nettype none
module testbench import frame_codec_pkg::*;;
  // ------------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------------
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, v2 = 1'b0, dyn = 1'b0, cyc_start = 1'b0;
  logic tx_valid = 1'b0, rx_ready = 1'b1, flag = 1'b0, sync = 1'b0, clr = 1'b1;
  logic v2_swap = 1'b0;
  round_cfg_e  cfg = RC_STATIC;
  logic [9:0]  id = 10'h001;
  logic [3:0]  cnt = 4'h0;
  logic [7:0]  cyc = 8'h00, n_rounds = 8'h00;
  logic [95:0] pl = 96'hA1B2C3D4E5F60718293A4B5C;
  logic tx_ready, tx_refused, rx_valid, same_flag, sync_o, acc, mis;
  logic acc_seen, mis_seen, ref_seen, full_seen;
  logic [9:0]  slot, prio;
  logic [3:0]  cnt_o;
  logic [7:0]  cyc_o, rc_tx, rc_rx, fmt_err, crc_err;
  logic [95:0] pl_o;
  int n_errors = 0, samples_checked = 0;
  frame_link_if link ();
  always #5 clk_sys_i = ~clk_sys_i;
  frame_tx_end frame_tx_end_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link(link.tx),
    .cycle_start_i(cyc_start), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .variant2_i(v2),
    .id_i(id), .same_slot_variant_flag_i(flag), .sync_i(sync), .payload_byte_count_i(cnt),
    .cycle_data_i(cyc), .payload_i(pl), .tx_refused_o(tx_refused), .round_count_o(rc_tx));
  frame_rx_end #(.BUF_DEPTH(FIFO_DEPTH)) frame_rx_end_i (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .link(link.rx), .variant2_i(v2 ^ v2_swap), .round_cfg_i(cfg),
    .dynamic_seg_i(dyn), .cycle_start_i(cyc_start), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .slot_o(slot), .priority_o(prio),
    .same_slot_variant_flag_o(same_flag), .sync_o(sync_o), .payload_byte_count_o(cnt_o),
    .cycle_field_o(cyc_o), .payload_o(pl_o), .sync_accept_o(acc), .round_mismatch_o(mis),
    .round_count_o(rc_rx), .format_err_cnt_o(fmt_err), .crc_err_cnt_o(crc_err));
  frame_link_properties frame_link_properties_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .valid(link.valid), .ready(link.ready), .data(link.data), .last(link.last));
  // pulses are one cycle wide, so latch them rather than poll
  always @(posedge clk_sys_i) begin
    acc_seen <= !clr && (acc_seen || acc);
    mis_seen <= !clr && (mis_seen || mis);
    ref_seen <= !clr && (ref_seen || tx_refused);
    full_seen <= !clr && (full_seen || !link.ready);
  end
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic final_report();
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  task automatic req();
    @(negedge clk_sys_i) clr = 1'b1;
    tx_valid = 1'b1;
    @(negedge clk_sys_i) tx_valid = 1'b0;
    clr = 1'b0;
  endtask : req
  task automatic expect_frame();
    int i = 0;
    logic [95:0] m;
    m = {96{1'b1}} >> (96 - 8 * cnt);
    while (rx_valid !== 1'b1 && i < 80) begin
      @(negedge clk_sys_i);
      i++;
    end
    chk(i < 80, 1'b1);
    chk(slot, dyn ? 10'h000 : id);
    chk(prio, dyn ? id : 10'h000);
    chk({same_flag, sync_o, cnt_o}, {flag, sync, cnt});
    chk(pl_o & m, pl & m);
    if (v2) begin
      chk(cyc_o, sync ? n_rounds : cyc);
    end
    @(negedge clk_sys_i);
    chk({acc_seen, mis_seen}, {sync && !dyn && cfg != RC_DYNAMIC, 1'b0});
    chk({fmt_err, crc_err}, 16'h0000);
  endtask : expect_frame
  task automatic frame(input logic v, input logic [9:0] i, input logic f, input logic s,
                       input logic [3:0] c, input logic bad);
    v2 = v;
    id = i;
    flag = f;
    sync = s;
    cnt = c;
    req();
    if (bad) begin
      repeat (2) @(negedge clk_sys_i);
      chk({ref_seen, rx_valid}, 2'b10);
    end else begin
      expect_frame();
    end
  endtask : frame
  task automatic rounds(input int n);
    repeat (n) begin
      @(negedge clk_sys_i) cyc_start = 1'b1;
      @(negedge clk_sys_i) cyc_start = 1'b0;
      n_rounds++;
    end
    chk({rc_tx, rc_rx}, {n_rounds, n_rounds});
  endtask : rounds
  initial begin
    #100us;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (6) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    chk({tx_ready, link.ready, rx_valid, rc_tx}, {3'b110, 8'h00});
    rounds(3);
    frame(0, 10'h001, 0, 0, 4'h0, 0);
    frame(0, 10'h3FF, 1, 1, 4'hC, 0);
    frame(0, 10'h000, 0, 0, 4'h3, 1);
    frame(0, 10'h055, 0, 0, 4'hD, 1);
    frame(1, 10'h101, 0, 1, 4'hC, 1);
    frame(1, 10'h101, 0, 1, 4'hB, 0);
    cyc = 8'h5A;
    frame(1, 10'h102, 1, 0, 4'h4, 0);
    dyn = 1'b1;
    frame(0, 10'h2AA, 0, 1, 4'h2, 0);
    dyn = 1'b0;
    for (int k = 0; k < 3; k++) begin
      cfg = round_cfg_e'(k);
      frame(0, 10'h0F0, 0, 1, 4'h1, 0);
    end
    rounds(255);
    rounds(2);
    frame(1, 10'h111, 0, 1, 4'h0, 0);
    // hold the first frame so the second one backs up into the buffer
    rx_ready = 1'b0;
    frame(0, 10'h123, 0, 0, 4'hC, 0);
    id = 10'h124;
    req();
    repeat (12) @(negedge clk_sys_i);
    chk(full_seen, 1'b1);
    rx_ready = 1'b1;
    @(negedge clk_sys_i);
    chk(rx_valid, 1'b0);
    expect_frame();
    // receiver set for variant two while the sender sends variant one
    v2_swap = 1'b1;
    id = 10'h077;
    req();
    repeat (24) @(negedge clk_sys_i);
    chk({fmt_err, rx_valid, ref_seen}, {8'h01, 2'b00});
    final_report();
  end
endmodule : testbench
`default_nettype wire
